/* pkg/boost_seq_defines.svh */
/*
 * Offsets, field positions, reset values and timing counts of the boost start-up sequencer.
 * Assumes a 100 MHz system clock; included by bare name from rtl/ and verification/.
 */
`ifndef BOOST_SEQ_DEFINES_SVH
`define BOOST_SEQ_DEFINES_SVH

`define CLK_PERIOD_NS      10
`define MODE_LATCH_US      195
`define LOCK_WAIT_US       700
`define PREBIAS_US         50
`define PG_DE_US           500
`define PG_CCM_MS          100
`define FAULT_FILTER_US    10
`define SYNC_LATENCY_NS    35
`define LOSS_FREQ_HZ       37000

`define MODE_LATCH_CYC     ((`MODE_LATCH_US * 1000) / `CLK_PERIOD_NS)
`define LOCK_WAIT_CYC      ((`LOCK_WAIT_US * 1000) / `CLK_PERIOD_NS)
`define PREBIAS_CYC        ((`PREBIAS_US * 1000) / `CLK_PERIOD_NS)
`define PG_DE_CYC          ((`PG_DE_US * 1000) / `CLK_PERIOD_NS)
`define PG_CCM_CYC         ((`PG_CCM_MS * 1000000) / `CLK_PERIOD_NS)
`define FAULT_FILTER_CYC   ((`FAULT_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LATENCY_CYC   ((`SYNC_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOSS_CYC           (1000000000 / (`LOSS_FREQ_HZ * `CLK_PERIOD_NS))

`define REG_CTRL           5'h00
`define REG_PERIOD         5'h04
`define REG_DEAD           5'h08
`define REG_MINON          5'h0C
`define REG_STATUS         5'h10

`define CTRL_PHDROP_BIT    0
`define ST_SYNCED_BIT      4
`define ST_LOCKLOSS_BIT    5
`define ST_HICCUP_BIT      6
`define ST_DE_BIT          7
`define ST_TRACK_BIT       8
`define ST_POWER_GOOD_BIT       9
`define ST_SSDONE_BIT      10
`define ST_PHDROP_BIT      11

`define PERIOD_RST         16'h014D
`define DEAD_RST           8'h03
`define MINON_RST          16'h000A

`endif

/* pkg/boost_seq_pkg.sv */
/*
 * Types of the boost start-up sequencer: state enum, comparator and gate bundles, state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package boost_seq_pkg;

	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_MODE_LATCH,
		ST_LOCK_WAIT,
		ST_PREBIAS,
		ST_RAMP,
		ST_PG_DELAY,
		ST_RUN,
		ST_FAULT
	} state_t;

	typedef struct packed {
		logic       en_rise;
		logic       en_fall;
		logic       por_ok;
		logic       ss_clamp;
		logic       trk_ok;
		logic       comp_ok;
		logic       fb_uv;
		logic       fb_ov;
		logic       vin_ov;
		logic [1:0] zero_cur;
		logic [1:0] cs_trip;
	} cmp_t;

	typedef struct packed {
		logic [1:0] low_gate;
		logic [1:0] high_gate;
	} gate_t;

	typedef struct packed {
		state_t           state;
		logic [23:0]      timer;
		logic [15:0]      cnt;
		logic [15:0]      sync_per;
		logic [15:0]      since;
		logic [2:0]       lat;
		logic             sync_seen;
		logic             synced;
		logic             sync_ignore;
		logic             sync_d;
		logic             en_ok;
		logic             hiccup;
		logic             de_mode;
		logic             track;
		logic             lock_loss;
		logic             clk_out;
		logic [15:0]      clkw;
		gate_t            gate;
		logic [1:0][15:0] minon;
		logic [1:0][15:0] hgcnt;
		logic [15:0]      soft_w;
		logic [15:0]      soft_step;
		logic [15:0]      flt_cnt;
		logic             pg_low;
		logic             pg_recover;
		logic             ss_done;
		logic             prebias;
		logic             ss_ramp;
		logic             drv_en;
		logic             phdrop_req;
		logic             phdrop_act;
		logic [15:0]      period;
		logic [7:0]       dead;
		logic [15:0]      min_on;
		logic [31:0]      rdata;
	} seq_t;

endpackage

`default_nettype wire

/* rtl/boost_seq.sv */
/*
 * Start-up sequencer and clock synchroniser of a two-phase boost controller.
 * Assumes comparator flags and the sync pin are synchronous to SYS_CLK, and that a
 * plain register port (address, strobes, one-cycle read latency) sits outside.
 */
`include "boost_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module boost_seq #(
	parameter int MODE_LATCH_CYC = `MODE_LATCH_CYC,
	parameter int LOCK_WAIT_CYC  = `LOCK_WAIT_CYC,
	parameter int PREBIAS_CYC    = `PREBIAS_CYC,
	parameter int PG_DE_CYC      = `PG_DE_CYC,
	parameter int PG_CCM_CYC     = `PG_CCM_CYC
) (
	input  wire logic                  SYS_CLK,
	input  wire logic                  RST_N,
	input  wire logic                  CE,
	input  wire logic                  SYNC_FREQ_PIN,
	input  wire logic                  FAULT_RESPONSE_SELECT,
	input  wire logic                  LIGHT_LOAD_SELECT,
	input  wire logic                  TRACK_MODE_SELECT,
	input  wire boost_seq_pkg::cmp_t   CMP,
	input  wire logic [4:0]            ADDR,
	input  wire logic [31:0]           WDATA,
	input  wire logic                  WR_STB,
	input  wire logic                  RD_STB,
	output logic [31:0]                RDATA,
	output boost_seq_pkg::gate_t       GATES,
	output logic                       PHASE_CLOCK_OUT,
	output logic                       SS_PREBIAS,
	output logic                       SS_RAMP_EN,
	output logic                       DRIVER_EN,
	output logic                       POWER_GOOD_OUT,
	output logic                       POWER_GOOD_OE
);

	localparam int SOFT_STEP_CYC = (PG_CCM_CYC / 65536) + 1;
	localparam int FLT_CYC       = `FAULT_FILTER_CYC;
	localparam int LOSS_CYC      = `LOSS_CYC;
	localparam int LAT_CYC       = `SYNC_LATENCY_CYC;

	boost_seq_pkg::seq_t st_ff;
	boost_seq_pkg::seq_t nxt_st;

	logic [15:0] per;
	logic        sync_edge;
	logic        osc_run;
	logic        sw_ok;
	logic        any_flt;
	logic        lock_lost;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] lg_start(input logic ph, input logic [15:0] p,
		input logic [7:0] d);
		lg_start = (ph ? (p >> 1) : 16'h0000) + {8'h00, d};
	endfunction

	function automatic logic [15:0] twelfth(input logic [15:0] p);
		twelfth = (p < 16'h000C) ? 16'h0001 : p / 16'h000C;
	endfunction

	function automatic logic [31:0] read_reg(input logic [4:0] a, input boost_seq_pkg::seq_t s);
		read_reg = 32'h00000000;
		case (a)
			`REG_CTRL:   read_reg[`CTRL_PHDROP_BIT] = s.phdrop_req;
			`REG_PERIOD: read_reg[15:0] = s.period;
			`REG_DEAD:   read_reg[7:0] = s.dead;
			`REG_MINON:  read_reg[15:0] = s.min_on;
			`REG_STATUS:
			begin
				read_reg[3:0] = 4'(s.state);
				read_reg[`ST_SYNCED_BIT] = s.synced;
				read_reg[`ST_LOCKLOSS_BIT] = s.lock_loss;
				read_reg[`ST_HICCUP_BIT] = s.hiccup;
				read_reg[`ST_DE_BIT] = s.de_mode;
				read_reg[`ST_TRACK_BIT] = s.track;
				read_reg[`ST_POWER_GOOD_BIT] = ~s.pg_low;
				read_reg[`ST_SSDONE_BIT] = s.ss_done;
				read_reg[`ST_PHDROP_BIT] = s.phdrop_act;
			end
			default: read_reg = 32'h00000000;
		endcase
	endfunction

	// in sync mode the period is the measured edge spacing; otherwise the programmed one
	assign per       = st_ff.synced ? st_ff.sync_per : st_ff.period;
	assign sync_edge = SYNC_FREQ_PIN & ~st_ff.sync_d;
	assign osc_run   = st_ff.state inside {boost_seq_pkg::ST_PREBIAS, boost_seq_pkg::ST_RAMP,
		boost_seq_pkg::ST_PG_DELAY, boost_seq_pkg::ST_RUN};
	assign sw_ok     = CMP.comp_ok & st_ff.state inside {boost_seq_pkg::ST_RAMP,
		boost_seq_pkg::ST_PG_DELAY, boost_seq_pkg::ST_RUN};
	assign any_flt   = CMP.fb_uv | CMP.fb_ov | CMP.vin_ov;
	// a programmed period slower than the floor counts as lost lock too
	assign lock_lost = osc_run & ((st_ff.synced & (st_ff.since >= 16'(LOSS_CYC))) |
		(~st_ff.synced & (st_ff.period > 16'(LOSS_CYC))));

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rdata = 32'h00000000;
		nxt_st.sync_d = SYNC_FREQ_PIN;
		if (CMP.en_rise)
			nxt_st.en_ok = 1'b1;
		else if (CMP.en_fall)
			nxt_st.en_ok = 1'b0;

		if (WR_STB)
		begin
			case (ADDR)
				`REG_CTRL:   nxt_st.phdrop_req = WDATA[`CTRL_PHDROP_BIT];
				`REG_PERIOD: nxt_st.period = WDATA[15:0];
				`REG_DEAD:   nxt_st.dead = WDATA[7:0];
				`REG_MINON:  nxt_st.min_on = WDATA[15:0];
				default:     nxt_st.rdata = 32'h00000000;
			endcase
		end
		if (RD_STB)
			nxt_st.rdata = read_reg(ADDR, st_ff);

		// edge spacing measurement; pulse width never enters the decision
		if (st_ff.since != 16'hFFFF)
			nxt_st.since = st_ff.since + 16'h0001;
		if (st_ff.lat != 3'h0)
			nxt_st.lat = st_ff.lat - 3'h1;
		if (sync_edge && !st_ff.sync_ignore)
		begin
			nxt_st.since = 16'h0000;
			nxt_st.lat = 3'(LAT_CYC);
			nxt_st.sync_per = st_ff.since + 16'h0001;
			nxt_st.sync_seen = 1'b1;
			if (st_ff.sync_seen && st_ff.since < 16'(LOSS_CYC))
				nxt_st.synced = 1'b1;
		end

		// once synced, the cycle counter restarts a fixed latency after each sync edge
		if (!osc_run)
			nxt_st.cnt = 16'h0000;
		else if (st_ff.synced && st_ff.lat == 3'h1)
			nxt_st.cnt = 16'h0000;
		else if (st_ff.cnt >= per - 16'h0001)
			nxt_st.cnt = 16'h0000;
		else
			nxt_st.cnt = st_ff.cnt + 16'h0001;

		// phase clock: low gate 0 rises at dead time, so quarter period lands dead time earlier
		if (osc_run && st_ff.cnt == (per >> 2))
		begin
			nxt_st.clk_out = 1'b1;
			nxt_st.clkw = twelfth(per);
		end
		else if (st_ff.clkw > 16'h0001)
			nxt_st.clkw = st_ff.clkw - 16'h0001;
		else
		begin
			nxt_st.clk_out = 1'b0;
			nxt_st.clkw = 16'h0000;
		end

		for (int i = 0; i < 2; i++)
		begin
			if (st_ff.minon[i] != 16'h0000)
				nxt_st.minon[i] = st_ff.minon[i] - 16'h0001;
			if (st_ff.hgcnt[i] != 16'hFFFF)
				nxt_st.hgcnt[i] = st_ff.hgcnt[i] + 16'h0001;
			if (!sw_ok || (i == 1 && st_ff.phdrop_act))
			begin
				nxt_st.gate.low_gate[i] = 1'b0;
				nxt_st.gate.high_gate[i] = 1'b0;
			end
			else if (st_ff.cnt == lg_start(i[0], per, st_ff.dead))
			begin
				nxt_st.gate.low_gate[i] = 1'b1;
				nxt_st.gate.high_gate[i] = 1'b0;
				nxt_st.minon[i] = st_ff.min_on;
			end
			// current sense is ignored until the blanking count has run out
			else if (st_ff.gate.low_gate[i] && st_ff.minon[i] == 16'h0000 && CMP.cs_trip[i])
			begin
				nxt_st.gate.low_gate[i] = 1'b0;
				nxt_st.gate.high_gate[i] = 1'b1;
				nxt_st.hgcnt[i] = 16'h0000;
			end
			else if (st_ff.gate.high_gate[i] && CMP.zero_cur[i] &&
				(st_ff.state == boost_seq_pkg::ST_RAMP || st_ff.de_mode))
				nxt_st.gate.high_gate[i] = 1'b0;
			else if (st_ff.gate.high_gate[i] && CMP.zero_cur[i] && !st_ff.pg_recover &&
				st_ff.state == boost_seq_pkg::ST_PG_DELAY && st_ff.hgcnt[i] >= st_ff.soft_w)
				nxt_st.gate.high_gate[i] = 1'b0;
		end

		if (any_flt)
		begin
			if (st_ff.flt_cnt != 16'hFFFF)
				nxt_st.flt_cnt = st_ff.flt_cnt + 16'h0001;
		end
		else
			nxt_st.flt_cnt = 16'h0000;

		if (st_ff.timer != 24'h000000)
			nxt_st.timer = st_ff.timer - 24'h000001;

		case (st_ff.state)
			boost_seq_pkg::ST_SHUTDOWN:
			begin
				if (st_ff.en_ok && CMP.por_ok)
				begin
					nxt_st.state = boost_seq_pkg::ST_MODE_LATCH;
					nxt_st.timer = 24'(MODE_LATCH_CYC - 1);
				end
			end
			boost_seq_pkg::ST_MODE_LATCH:
			begin
				if (st_ff.timer == 24'h000000)
				begin
					nxt_st.hiccup = FAULT_RESPONSE_SELECT;
					nxt_st.de_mode = LIGHT_LOAD_SELECT;
					nxt_st.track = TRACK_MODE_SELECT;
					nxt_st.state = boost_seq_pkg::ST_LOCK_WAIT;
					nxt_st.timer = 24'(LOCK_WAIT_CYC - 1);
				end
			end
			boost_seq_pkg::ST_LOCK_WAIT:
			begin
				if (st_ff.timer == 24'h000000)
				begin
					nxt_st.state = boost_seq_pkg::ST_PREBIAS;
					nxt_st.timer = 24'(PREBIAS_CYC - 1);
				end
			end
			boost_seq_pkg::ST_PREBIAS:
			begin
				if (st_ff.timer == 24'h000000)
					nxt_st.state = boost_seq_pkg::ST_RAMP;
			end
			boost_seq_pkg::ST_RAMP:
			begin
				if (CMP.ss_clamp && CMP.trk_ok)
				begin
					nxt_st.ss_done = 1'b1;
					nxt_st.state = boost_seq_pkg::ST_PG_DELAY;
					nxt_st.timer = st_ff.de_mode ? 24'(PG_DE_CYC - 1) : 24'(PG_CCM_CYC - 1);
					nxt_st.soft_w = 16'h0000;
					nxt_st.soft_step = 16'h0000;
				end
			end
			boost_seq_pkg::ST_PG_DELAY:
			begin
				// after a comparator fault the 0.5 ms only starts once the fault has gone
				if (st_ff.pg_recover && any_flt)
					nxt_st.timer = 24'(PG_DE_CYC - 1);
				else if (st_ff.timer == 24'h000000)
				begin
					nxt_st.state = boost_seq_pkg::ST_RUN;
					nxt_st.pg_low = 1'b0;
					nxt_st.pg_recover = 1'b0;
				end
				if (!st_ff.de_mode && !st_ff.pg_recover)
				begin
					if (st_ff.soft_step >= 16'(SOFT_STEP_CYC - 1))
					begin
						nxt_st.soft_step = 16'h0000;
						if (st_ff.soft_w != 16'hFFFF)
							nxt_st.soft_w = st_ff.soft_w + 16'h0001;
					end
					else
						nxt_st.soft_step = st_ff.soft_step + 16'h0001;
				end
			end
			boost_seq_pkg::ST_RUN:
			begin
				if (st_ff.flt_cnt >= 16'(FLT_CYC))
				begin
					nxt_st.pg_low = 1'b1;
					nxt_st.pg_recover = 1'b1;
					nxt_st.state = boost_seq_pkg::ST_PG_DELAY;
					nxt_st.timer = 24'(PG_DE_CYC - 1);
				end
			end
			boost_seq_pkg::ST_FAULT:
				nxt_st.pg_low = 1'b1;
			default:
				nxt_st.state = boost_seq_pkg::ST_SHUTDOWN;
		endcase

		if (lock_lost)
		begin
			nxt_st.lock_loss = 1'b1;
			nxt_st.synced = 1'b0;
			nxt_st.sync_seen = 1'b0;
			nxt_st.pg_low = 1'b1;
			nxt_st.ss_done = 1'b0;
			if (st_ff.hiccup)
			begin
				nxt_st.sync_ignore = 1'b1;
				nxt_st.state = boost_seq_pkg::ST_LOCK_WAIT;
				nxt_st.timer = 24'(LOCK_WAIT_CYC - 1);
			end
			else
				nxt_st.state = boost_seq_pkg::ST_FAULT;
		end

		if (!nxt_st.en_ok || !CMP.por_ok)
		begin
			nxt_st.state = boost_seq_pkg::ST_SHUTDOWN;
			nxt_st.lock_loss = 1'b0;
			nxt_st.synced = 1'b0;
			nxt_st.sync_seen = 1'b0;
			nxt_st.sync_ignore = 1'b0;
			nxt_st.pg_low = 1'b1;
			nxt_st.pg_recover = 1'b0;
			nxt_st.ss_done = 1'b0;
		end

		nxt_st.prebias = (nxt_st.state == boost_seq_pkg::ST_PREBIAS);
		nxt_st.ss_ramp = (nxt_st.state == boost_seq_pkg::ST_RAMP);
		nxt_st.drv_en = nxt_st.state inside {boost_seq_pkg::ST_RAMP,
			boost_seq_pkg::ST_PG_DELAY, boost_seq_pkg::ST_RUN};
		nxt_st.phdrop_act = nxt_st.phdrop_req & ~nxt_st.synced & nxt_st.de_mode &
			(nxt_st.state == boost_seq_pkg::ST_RUN);
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			st_ff <= '0;
			st_ff.period <= `PERIOD_RST;
			st_ff.dead <= `DEAD_RST;
			st_ff.min_on <= `MINON_RST;
			st_ff.pg_low <= 1'b1;
		end
		else if (CE)
			st_ff <= nxt_st;
	end

	assign RDATA           = st_ff.rdata;
	assign GATES           = st_ff.gate;
	assign PHASE_CLOCK_OUT = st_ff.clk_out;
	assign SS_PREBIAS      = st_ff.prebias;
	assign SS_RAMP_EN      = st_ff.ss_ramp;
	assign DRIVER_EN       = st_ff.drv_en;
	assign POWER_GOOD_OUT  = 1'b0;
	assign POWER_GOOD_OE   = st_ff.pg_low;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	shutdown_on_por_a: assert property ((CE && !CMP.por_ok) |=> st_ff.state == boost_seq_pkg::ST_SHUTDOWN) else $error("supply drop did not shut down");
	start_gate_a: assert property ((CE && st_ff.state == boost_seq_pkg::ST_SHUTDOWN && !st_ff.en_ok && !CMP.en_rise) |=> st_ff.state == boost_seq_pkg::ST_SHUTDOWN) else $error("left shutdown without enable");
	mode_latch_end_a: assert property (($past(st_ff.state) == boost_seq_pkg::ST_MODE_LATCH && st_ff.state == boost_seq_pkg::ST_LOCK_WAIT) |-> $past(st_ff.timer) == 24'h000000) else $error("mode latch ended early");
	phase_clock_out_phase_a: assert property ($rose(st_ff.clk_out) |-> $past(st_ff.cnt) == ($past(per) >> 2)) else $error("phase clock started at wrong count");
	phase_clock_out_width_a: assert property (($fell(st_ff.clk_out) && $past(st_ff.clkw) != 16'h0000) |-> $past(st_ff.clkw) == 16'h0001) else $error("phase clock width wrong");
	sync_restart_a: assert property ((CE && osc_run && st_ff.synced && st_ff.lat == 3'h1 && nxt_st.state == st_ff.state) |=> st_ff.cnt == 16'h0000) else $error("cycle not restarted after sync latency");
	lg_min_on_a: assert property (($fell(st_ff.gate.low_gate[0]) && $past(sw_ok)) |-> $past(st_ff.minon[0]) == 16'h0000) else $error("low gate shorter than minimum");
	ss_done_gate_a: assert property ($rose(st_ff.ss_done) |-> $past(CMP.ss_clamp && CMP.trk_ok)) else $error("soft-start done without clamp and track");
	pg_release_a: assert property ($fell(st_ff.pg_low) |-> ($past(st_ff.state) == boost_seq_pkg::ST_PG_DELAY && $past(st_ff.timer) == 24'h000000)) else $error("power good released before delay");
	phdrop_sync_a: assert property (st_ff.synced |-> !st_ff.phdrop_act) else $error("phase drop while synchronised");
	lockloss_stop_a: assert property ($rose(st_ff.lock_loss) |-> (st_ff.state inside {boost_seq_pkg::ST_FAULT, boost_seq_pkg::ST_LOCK_WAIT} && !st_ff.synced)) else $error("oscillator kept running after lock loss");
	hiccup_internal_a: assert property (($rose(st_ff.lock_loss) && st_ff.hiccup) |-> (st_ff.sync_ignore && st_ff.state == boost_seq_pkg::ST_LOCK_WAIT)) else $error("hiccup restart not on internal clock");
	en_clear_a: assert property ((CE && CMP.en_fall && !CMP.en_rise) |=> (!st_ff.lock_loss && st_ff.state == boost_seq_pkg::ST_SHUTDOWN)) else $error("enable low did not clear faults");
	pg_filter_a: assert property (($rose(st_ff.pg_low) && st_ff.pg_recover) |-> $past(st_ff.flt_cnt) >= 16'(FLT_CYC)) else $error("power good dropped before filter time");

endmodule

`default_nettype wire

/* verification/sync_source.sv */
/*
 * Model of the external clock that drives the sync pin of the sequencer.
 * Assumes the bench gives it the system clock and a period in cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_source (
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic [15:0] period,
	output logic             sync_out
);
	logic [15:0] cnt = 16'h0000;

	initial sync_out = 1'b0;

	// --------------------------------
	// pulse train
	// --------------------------------
	always @(posedge clk)
	begin
		if (!run)
		begin
			cnt <= 16'h0000;
			sync_out <= 1'b0; // pin has a resistor to ground, so a removed clock reads low
		end
		else
		begin
			cnt <= (cnt == period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
			sync_out <= (cnt < 16'h0003); // 30 ns wide, only the edge should matter
		end
	end
endmodule

`default_nettype wire

/* verification/boost_startup_sync_sequencer_bench.sv */
/*
 * Self-checking bench of the boost start-up sequencer: bus tasks, sequence and sync tests.
 * Assumes the sync_source model and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "boost_seq_defines.svh"

module boost_startup_sync_sequencer_bench;
	localparam int ML = 20;
	localparam int LW = 30;
	localparam int PB = 10;
	localparam int PD = 20;
	localparam int PC = 40;
	localparam int P  = 120;
	localparam int DT = 3;
	localparam logic [31:0] ST     = 32'h0000000F;
	localparam logic [31:0] B_SYNC = 32'h00000001 << `ST_SYNCED_BIT;
	localparam logic [31:0] B_LOSS = 32'h00000001 << `ST_LOCKLOSS_BIT;
	localparam logic [31:0] B_HIC  = 32'h00000001 << `ST_HICCUP_BIT;
	localparam logic [31:0] B_DE   = 32'h00000001 << `ST_DE_BIT;
	localparam logic [31:0] B_TRK  = 32'h00000001 << `ST_TRACK_BIT;
	localparam logic [31:0] B_DROP = 32'h00000001 << `ST_PHDROP_BIT;

	logic        sys_clk, rst_n, ce, fault_sel, light_sel, track_sel, sync_run, sync_pin;
	logic        wr_stb, rd_stb, clk_out, ss_pb, ss_ramp, drv_en, pg_out, pg_oe;
	logic [4:0]  addr, hist;
	logic [31:0] wdata, rdata;
	logic [15:0] sync_per;
	logic [3:0]  obs;
	boost_seq_pkg::cmp_t  cmp;
	boost_seq_pkg::gate_t gates;
	int          failures, checks, cyc, t_sync, t_lg, d_lg, w_lg, t_cr, p_clk, w_clk, d_clk;
	int          t_pb, w_pb, t_pg, t_ss, nclk, n0;

	boost_seq #(.MODE_LATCH_CYC(ML), .LOCK_WAIT_CYC(LW), .PREBIAS_CYC(PB), .PG_DE_CYC(PD),
		.PG_CCM_CYC(PC)) u_boost_seq (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .SYNC_FREQ_PIN(sync_pin),
		.FAULT_RESPONSE_SELECT(fault_sel), .LIGHT_LOAD_SELECT(light_sel),
		.TRACK_MODE_SELECT(track_sel), .CMP(cmp), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .GATES(gates),
		.PHASE_CLOCK_OUT(clk_out), .SS_PREBIAS(ss_pb), .SS_RAMP_EN(ss_ramp),
		.DRIVER_EN(drv_en), .POWER_GOOD_OUT(pg_out), .POWER_GOOD_OE(pg_oe));

	sync_source u_sync_source (.clk(sys_clk), .run(sync_run), .period(sync_per),
		.sync_out(sync_pin));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// --------------------------------
	// edge timestamps, sampled on the clock so all spacings are in cycles
	// --------------------------------
	assign obs = {pg_oe, ss_pb, ss_ramp, clk_out};

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		hist <= {sync_pin, gates.low_gate[0], clk_out, ss_pb, pg_oe};
		if (sync_pin && !hist[4]) t_sync <= cyc;
		if (gates.low_gate[0] && !hist[3])
		begin
			t_lg <= cyc;
			d_lg <= cyc - t_sync;
		end
		if (!gates.low_gate[0] && hist[3]) w_lg <= cyc - t_lg;
		if (clk_out && !hist[2])
		begin
			t_cr <= cyc;
			p_clk <= cyc - t_cr;
			d_clk <= cyc - t_lg;
			nclk <= nclk + 1;
		end
		if (!clk_out && hist[2]) w_clk <= cyc - t_cr;
		if (ss_pb && !hist[1]) t_pb <= cyc;
		if (!ss_pb && hist[1]) w_pb <= cyc - t_pb;
		if (!pg_oe && hist[0]) t_pg <= cyc;
	end

	// --------------------------------
	// tasks
	// --------------------------------
	function automatic logic in_rng(input int v, input int lo, input int hi);
		return (v >= lo && v <= hi);
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		// read data stand in this cycle only; taken at its closing edge
		@(posedge sys_clk);
		chk(what, rdata & m, e);
	endtask

	// waits on obs[k] at the falling edge, then two edges so the timestamps have landed
	task automatic wait_for(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[k] !== v && n < lim)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk("wait", obs[k], v);
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#300000;
		failures++;
		close_out();
	end

	initial
	begin
		{rst_n, wr_stb, rd_stb, sync_run, fault_sel} = 5'h00;
		{ce, light_sel, track_sel} = 3'h7;
		cmp = '0;
		addr = 5'h00;
		wdata = 32'h00000000;
		sync_per = 16'h0078;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk("oe after reset", pg_oe, 1'b1);
		rchk("dead reset", `REG_DEAD, 32'hFFFFFFFF, 32'h00000003);
		rchk("minon reset", `REG_MINON, 32'hFFFFFFFF, 32'h0000000A);
		rchk("unmapped", 5'h14, 32'hFFFFFFFF, 32'h00000000);
		cmp.en_rise <= 1'b1;
		sync_run <= 1'b1;
		repeat (60) @(posedge sys_clk);
		rchk("held off", `REG_STATUS, ST, 32'h00000000);
		chk("gates off", gates, 32'h00000000);
		$display("test shutdown hold done");
		cmp.en_rise <= 1'b0;
		cmp.por_ok <= 1'b1;
		n0 = cyc;
		wait_for(2, 1'b1, ML + LW + 20);
		chk("start delay", in_rng(t_pb - n0, ML + LW, ML + LW + 5), 1'b1);
		wait_for(1, 1'b1, PB + 10);
		chk("prebias width", w_pb, PB);
		rchk("modes", `REG_STATUS, ST | B_HIC | B_DE | B_TRK | B_SYNC,
			32'h4 | B_DE | B_TRK);
		chk("drivers on", drv_en, 1'b1);
		chk("no switching", t_lg, 0);
		cmp.comp_ok <= 1'b1;
		cmp.cs_trip <= 2'b11;
		repeat (4 * P) @(posedge sys_clk);
		chk("sync period", p_clk, P);
		chk("clock width", w_clk, P / 12);
		chk("clock offset", d_clk, P / 4 - DT);
		chk("edge to gate", in_rng(d_lg, DT + 4, DT + 7), 1'b1);
		chk("min on", w_lg, 11);
		chk("one gate on", gates.low_gate[0] ^ gates.high_gate[0], 1'b1);
		$display("test sync done");
		cmp.ss_clamp <= 1'b1;
		repeat (30) @(posedge sys_clk);
		chk("ramp holds", ss_ramp, 1'b1);
		cmp.trk_ok <= 1'b1;
		t_ss = cyc;
		wait_for(3, 1'b0, PD + 20);
		chk("de pg delay", in_rng(t_pg - t_ss, PD, PD + 5), 1'b1);
		wr(`REG_CTRL, 32'h00000001);
		repeat (20) @(posedge sys_clk);
		rchk("no drop", `REG_STATUS, B_DROP | ST, 32'h00000006);
		cmp.fb_uv <= 1'b1;
		repeat (500) @(posedge sys_clk);
		cmp.fb_uv <= 1'b0;
		chk("glitch ignored", pg_oe, 1'b0);
		cmp.vin_ov <= 1'b1;
		repeat (1100) @(posedge sys_clk);
		chk("fault pulls low", pg_oe, 1'b1);
		cmp.vin_ov <= 1'b0;
		wait_for(3, 1'b0, PD + 20);
		$display("test start-up done");
		sync_run <= 1'b0;
		repeat (2800) @(posedge sys_clk);
		rchk("latch off", `REG_STATUS, ST | B_LOSS, 32'h7 | B_LOSS);
		n0 = nclk;
		repeat (300) @(posedge sys_clk);
		chk("osc stopped", nclk - n0, 0);
		chk("pg on fault", pg_oe, 1'b1);
		cmp.en_fall <= 1'b1;
		@(posedge sys_clk);
		cmp.en_fall <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rchk("enable low", `REG_STATUS, ST | B_LOSS, 32'h00000000);
		chk("drivers off", {drv_en, gates}, 32'h00000000);
		$display("test latch-off done");
		fault_sel <= 1'b1;
		light_sel <= 1'b0;
		cmp.ss_clamp <= 1'b0;
		cmp.trk_ok <= 1'b0;
		wr(`REG_PERIOD, 32'h00000060);
		sync_run <= 1'b1;
		cmp.en_rise <= 1'b1;
		@(posedge sys_clk);
		cmp.en_rise <= 1'b0;
		wait_for(1, 1'b1, ML + LW + PB + 30);
		rchk("ccm modes", `REG_STATUS, ST | B_HIC | B_DE, 32'h4 | B_HIC);
		cmp.ss_clamp <= 1'b1;
		cmp.trk_ok <= 1'b1;
		t_ss = cyc;
		wait_for(3, 1'b0, PC + 20);
		chk("ccm pg delay", in_rng(t_pg - t_ss, PC, PC + 5), 1'b1);
		// lock needs a second sync edge after leaving shutdown
		repeat (2 * P) @(posedge sys_clk);
		rchk("ccm synced", `REG_STATUS, B_SYNC, B_SYNC);
		sync_run <= 1'b0;
		repeat (2800) @(posedge sys_clk);
		rchk("hiccup", `REG_STATUS, B_HIC | B_LOSS, B_HIC | B_LOSS);
		repeat (600) @(posedge sys_clk);
		chk("internal period", p_clk, 96);
		chk("pg level", pg_out, 1'b0);
		ce <= 1'b0;
		n0 = nclk;
		repeat (300) @(posedge sys_clk);
		chk("frozen clock", nclk - n0, 0);
		$display("test hiccup done");
		close_out();
	end
endmodule

`default_nettype wire
